// ---- scr_clk_div.sv ----
// Flip-flop divider that makes the transmit step pulse from the reference, plus the transmit core clock at divide by two or four.
`default_nettype none
module scr_clk_div
  import scr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [1:0] ratio,
  output logic clk_out,
  output logic tick
);
  typedef struct packed {
    logic [1:0] cnt;
    logic clk;
    logic tick;
  } scr_div_s;
  scr_div_s q;
  scr_div_s next_q;
  logic [1:0] last;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_comb begin
    next_q = q;
    last = (ratio == DIV_BY4) ? 2'h3 : ((ratio == DIV_BY2) ? 2'h1 : 2'h0);
    if (ce) begin
      // divide by one, two or four
      next_q.cnt = (q.cnt == last) ? 2'h0 : q.cnt + 2'h1;
      next_q.tick = (next_q.cnt == last);
      next_q.clk = (ratio == DIV_BY4) ? next_q.cnt[1] : ((ratio == DIV_BY2) ? next_q.cnt[0] : 1'b0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign clk_out = q.clk;
  assign tick = q.tick;

  a_div_spacing: assert property (@(posedge core_clk) disable iff (srst || !ce)
    (tick && ratio == DIV_BY4) |=> !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("divide-by-four step spacing wrong");
  a_div_half: assert property (@(posedge core_clk) disable iff (srst || !ce)
    (tick && ratio == DIV_BY2) |=> !tick ##1 tick)
    else $error("divide-by-two step spacing wrong");
endmodule
`default_nettype wire

// ---- scr_clock_reset.sv ----
// Clock-rate selection, transmit clock divider, domain resets and link start-up for the serial PHY.
`default_nettype none
module scr_clock_reset
  import scr_pkg::*;
#(
  parameter logic [1:0] BAUD = BAUD_3G125,
  parameter bit FOUR_LANE = 1'b0,
  parameter bit INTERNAL_XCVR = 1'b1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic ext_reset_req,
  input wire logic reconfig_busy,
  input wire logic pll_locked,
  input wire logic clock_recovery_unit_locked,
  input wire logic peer_active,
  output scr_rst_s rst,
  output scr_xcvr_rst_s xcvr_rst,
  output scr_rate_s rate,
  output logic tx_core_clk,
  output logic tx_core_tick,
  output logic seq_done,
  output logic phy_dis,
  output scr_link_e link_state
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_sync;
    scr_seq_e seq;
    scr_link_e link;
    logic [15:0] timer;
    scr_xcvr_rst_s xr;
    scr_rate_s rate;
  } scr_state_s;
  scr_state_s q;
  scr_state_s next_q;

  logic rst_src;
  logic rx_step;
  logic [NUM_DOM-1:0] dom_step;
  logic [NUM_DOM-1:0] dom_req;
  logic [NUM_DOM-1:0] dom_rst;
  logic [1:0] div_ratio;

  localparam logic [15:0] TX_HOLD_LAST = 16'(TX_HOLD_CYC - 1);
  localparam logic [15:0] SILENT_LAST = 16'(SILENT_CYC - 1);
  localparam logic [15:0] RECOVER_LAST = 16'(RECOVER_CYC - 1);

  // Domains fed by the divided transmit clock.
  function automatic logic dom_is_tx(input int d);
    dom_is_tx = (d == DOM_TX_XCVR) || (d == DOM_TX_CORE) || (d == DOM_TX_STRM);
  endfunction

  // Domains fed by the recovered receive clock.
  function automatic logic dom_is_rx(input int d);
    dom_is_rx = (d == DOM_RX_XCVR) || (d == DOM_RX_CORE) || (d == DOM_RX_STRM);
  endfunction

  // ------------------------------------------------------------
  // Transmit clock divider
  // ------------------------------------------------------------
  // build-time ratio
  assign div_ratio = FOUR_LANE ? DIV_BY1 : DIV_BY2;

  scr_clk_div u_div (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .ratio(div_ratio),
    .clk_out(tx_core_clk),
    .tick(tx_core_tick)
  );

  // ------------------------------------------------------------
  // Domain reset synchronizers
  // ------------------------------------------------------------
  // one common source for every reset
  assign rst_src = q.pin_sync[PIN_RST_REQ] | q.pin_sync[PIN_BUSY];
  // receive domains only step once recovery is locked
  assign rx_step = q.pin_sync[PIN_CRU_LOCK];

  for (genvar d = 0; d < NUM_DOM; d++) begin : g_dom
    // transmit and receive domains step on their own clocks
    assign dom_step[d] = dom_is_tx(d) ? tx_core_tick : (dom_is_rx(d) ? rx_step : 1'b1);
    // datapath domains wait for the sequencer
    assign dom_req[d] = rst_src | ((d != DOM_REG) && !(q.seq == SEQ_DONE))
                        | (dom_is_rx(d) && !rx_step);
    scr_rst_sync u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .step(dom_step[d]),
      .assert_req(dom_req[d]),
      .rst_out(dom_rst[d])
    );
  end

  // paired resets, each from its own domain
  assign rst.mgmt_reset = dom_rst[DOM_REG];
  assign rst.core_reset_n = ~dom_rst[DOM_TX_CORE];
  assign rst.dom_reset = dom_rst;

  // ------------------------------------------------------------
  // Transceiver reset sequencer and link start-up
  // ------------------------------------------------------------
  always_comb begin
    next_q = q;
    if (ce) begin
      // pins sampled on every cycle with ce high
      // Pin inputs cross two flops before anything reads them.
      next_q.pin_meta = {peer_active, clock_recovery_unit_locked, pll_locked, reconfig_busy, ext_reset_req};
      next_q.pin_sync = q.pin_meta;
      next_q.rate.xcvr_khz = scr_xcvr_khz(BAUD);
      next_q.rate.core_khz = scr_core_khz(BAUD, FOUR_LANE);
      if (q.timer != 16'h0000) begin
        next_q.timer = q.timer - 16'h0001;
      end
      // busy or request restarts the sequence
      if (rst_src) begin
        next_q.seq = SEQ_HOLD;
        next_q.xr = '{pll_reset: 1'b1, tx_xcvr_reset: 1'b1, rx_xcvr_reset: 1'b1};
      end else begin
        unique case (q.seq)
          SEQ_HOLD: begin
            if (INTERNAL_XCVR) begin
              next_q.seq = SEQ_PLL;
              next_q.xr.pll_reset = 1'b0;
            end else begin
              next_q.seq = SEQ_DONE;
              next_q.xr = '0;
            end
          end
          SEQ_PLL: begin
            if (q.pin_sync[PIN_PLL_LOCK]) begin
              next_q.seq = SEQ_TXREL;
              next_q.timer = TX_HOLD_LAST;
            end
          end
          SEQ_TXREL: begin
            if (q.timer == 16'h0000) begin
              next_q.seq = SEQ_CRU;
              next_q.xr.tx_xcvr_reset = 1'b0;
              next_q.xr.rx_xcvr_reset = 1'b0;
            end
          end
          SEQ_CRU: begin
            if (q.pin_sync[PIN_CRU_LOCK]) begin
              next_q.seq = SEQ_DONE;
            end
          end
          SEQ_DONE: begin
            // A lost PLL lock sends the sequence back to the start.
            if (INTERNAL_XCVR && !q.pin_sync[PIN_PLL_LOCK]) begin
              next_q.seq = SEQ_HOLD;
            end
          end
        endcase
      end
      // held in SILENT until the sequence completes
      if (next_q.seq != SEQ_DONE) begin
        next_q.link = LINK_SILENT;
        next_q.timer = (next_q.seq == SEQ_TXREL) ? next_q.timer : SILENT_LAST;
      end else begin
        unique case (q.link)
          LINK_SILENT: begin
            if (q.seq == SEQ_DONE && q.timer == 16'h0000) begin
              next_q.link = LINK_SEEK;
            end
          end
          LINK_SEEK: begin
            if (q.pin_sync[PIN_PEER]) begin
              next_q.link = LINK_INIT;
            end
          end
          LINK_INIT: begin
            // silent peer stops input, recovery is timed
            if (!q.pin_sync[PIN_PEER]) begin
              next_q.link = LINK_STOPPED;
              next_q.timer = RECOVER_LAST;
            end
          end
          LINK_STOPPED: begin
            if (q.timer == 16'h0000) begin
              next_q.link = LINK_SEEK;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '{pin_meta: '0, pin_sync: '0, seq: SEQ_HOLD, link: LINK_SILENT, timer: SILENT_LAST,
             xr: '{pll_reset: 1'b1, tx_xcvr_reset: 1'b1, rx_xcvr_reset: 1'b1}, rate: '0};
    end else begin
      q <= next_q;
    end
  end

  assign xcvr_rst = q.xr;
  assign rate = q.rate;
  assign seq_done = (q.seq == SEQ_DONE);
  assign link_state = q.link;
  // The transmitter is kept off while the link is silent.
  assign phy_dis = (q.link == LINK_SILENT);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_pair_assert: assert property (@(posedge core_clk) disable iff (srst || !ce)
    rst_src |=> rst.mgmt_reset && !rst.core_reset_n)
    else $error("paired resets not asserted together");
  a_busy_hold: assert property (@(posedge core_clk) disable iff (srst || !ce)
    q.pin_sync[PIN_BUSY] |=> (&rst.dom_reset) ##0 q.seq == SEQ_HOLD)
    else $error("reset released while reconfiguration busy");
  a_req_accept: assert property (@(posedge core_clk) disable iff (srst)
    (ce && ext_reset_req) ##1 ce ##1 ce |=> rst.mgmt_reset)
    else $error("reset request not taken within three cycles");
  a_silent_entry: assert property (@(posedge core_clk) disable iff (srst)
    $rose(seq_done) |-> link_state == LINK_SILENT && phy_dis)
    else $error("link not silent after reset sequence");
  a_stop_recover: assert property (@(posedge core_clk) disable iff (srst || !ce || rst_src)
    $rose(link_state == LINK_STOPPED) |-> ##[1:501] link_state == LINK_SEEK)
    else $error("input-error-stopped state never recovered");
  a_rx_gate: assert property (@(posedge core_clk) disable iff (srst || !ce)
    !rx_step |=> rst.dom_reset[DOM_RX_CORE] && rst.dom_reset[DOM_RX_STRM])
    else $error("receive domain out of reset without recovered clock");
  a_tx_release: assert property (@(posedge core_clk) disable iff (srst)
    $fell(rst.dom_reset[DOM_TX_CORE]) |-> $past(tx_core_tick))
    else $error("transmit core reset released off its clock");
  a_rate_pair: assert property (@(posedge core_clk) disable iff (srst)
    (rate.xcvr_khz != 20'h00000) |-> rate.core_khz == (FOUR_LANE ? rate.xcvr_khz : rate.xcvr_khz >> 1))
    else $error("core rate does not follow lane width");
  a_ext_no_seq: assert property (@(posedge core_clk) disable iff (srst || !ce)
    (!INTERNAL_XCVR && !rst_src && q.seq == SEQ_HOLD) |=> seq_done && !xcvr_rst.pll_reset)
    else $error("external build ran the transceiver sequence");
endmodule
`default_nettype wire

// ---- scr_clock_reset_test.sv ----
// Self-checking bench for clock rates, domain resets and link start-up.
`default_nettype none
module scr_clock_reset_test
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, srst, ce, reset_cmd, busy_cmd, peer_active;
  logic [1:0] lock_cmd;
  logic ext_reset_req, reconfig_busy, pll_locked, clock_recovery_unit_locked;
  scr_rst_s rst;
  scr_xcvr_rst_s xcvr_rst;
  scr_rate_s rate;
  logic tx_core_clk, tx_core_tick, seq_done, phy_dis;
  scr_link_e link_state;
  scr_rate_s g_rate [8];
  wire logic [7:0] g_tick;
  wire logic [7:0] g_done;
  int fail_count = 0;
  int n_tests = 0;
  // --------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------
  scr_clock_reset dut (
    .core_clk(core_clk), .srst(srst), .ce(ce), .ext_reset_req(ext_reset_req), .reconfig_busy(reconfig_busy),
    .pll_locked(pll_locked), .clock_recovery_unit_locked(clock_recovery_unit_locked), .peer_active(peer_active),
    .rst(rst), .xcvr_rst(xcvr_rst), .rate(rate), .tx_core_clk(tx_core_clk), .tx_core_tick(tx_core_tick),
    .seq_done(seq_done), .phy_dis(phy_dis), .link_state(link_state));
  // External builds for every rate and lane width; only rates, ticks and completion are judged.
  for (genvar i = 0; i < 8; i++) begin : g_var
    scr_clock_reset #(.BAUD(2'(i / 2)), .FOUR_LANE(1'(i % 2)), .INTERNAL_XCVR(1'b0)) u_var (
      .core_clk(core_clk), .srst(srst), .ce(ce), .ext_reset_req(ext_reset_req), .reconfig_busy(reconfig_busy),
      .pll_locked(pll_locked), .clock_recovery_unit_locked(clock_recovery_unit_locked),
      .peer_active(peer_active), .rst(), .xcvr_rst(), .rate(g_rate[i]), .tx_core_clk(),
      .tx_core_tick(g_tick[i]), .seq_done(g_done[i]), .phy_dis(), .link_state());
  end
  scr_far_model far (
    .core_clk(core_clk), .reset_cmd(reset_cmd), .busy_cmd(busy_cmd), .lock_cmd(lock_cmd), .xcvr_rst(xcvr_rst),
    .ext_reset_req(ext_reset_req), .reconfig_busy(reconfig_busy), .pll_locked(pll_locked),
    .clock_recovery_unit_locked(clock_recovery_unit_locked));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Summary: %0d compares, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_startup();
    int k;
    check(40'(rst), 40'h17F);
    check({37'h0, xcvr_rst}, 40'h7);
    check(40'({rate, seq_done, phy_dis, link_state}), 40'(6'h11));
    srst = 1'b0;
    for (k = 0; k < 400 && seq_done !== 1'b1; k++) step(1);
    check({37'h0, xcvr_rst}, 40'h0);
    check(40'({g_done, phy_dis, link_state}), 40'({8'hFF, 1'b1, LINK_SILENT}));
    for (k = 0; k < 30 && rst.dom_reset !== 7'h00; k++) step(1);
    check(40'(rst), 40'h080);
    step(SILENT_CYC - 30);
    check(40'(link_state), 40'(LINK_SILENT));
    $display("test startup done");
  endtask
  task automatic t_rates();
    logic [19:0] xk [4] = '{20'h0F424, 20'h1E848, 20'h2625A, 20'h3D090};
    logic [19:0] ck [4] = '{20'h07A12, 20'h0F424, 20'h1312D, 20'h1E848};
    for (int i = 0; i < 8; i++) begin
      check(40'(g_rate[i]), {xk[i / 2], (i % 2 == 1) ? xk[i / 2] : ck[i / 2]});
    end
    check(40'(rate), {xk[2], ck[2]});
    $display("test rates done");
  endtask
  task automatic t_divider();
    int n_main = 0;
    int n_one = 0;
    int n_two = 0;
    int n_clk = 0;
    for (int k = 0; k < 40; k++) begin
      step(1);
      n_main += int'(tx_core_tick === 1'b1);
      n_clk += int'(tx_core_clk === 1'b1);
      n_two += int'(g_tick[0] === 1'b1);
      n_one += int'(g_tick[1] === 1'b1);
    end
    check(40'(n_main), 40'h14);
    check(40'(n_clk), 40'h14);
    check(40'(n_two), 40'h14);
    check(40'(n_one), 40'h28);
    $display("test divider done");
  endtask
  task automatic t_link();
    int k;
    for (k = 0; k < 100 && link_state !== LINK_SEEK; k++) step(1);
    check(40'({phy_dis, link_state}), 40'({1'b0, LINK_SEEK}));
    peer_active = 1'b1;
    for (k = 0; k < 10 && link_state !== LINK_INIT; k++) step(1);
    check(40'(link_state), 40'(LINK_INIT));
    peer_active = 1'b0;
    for (k = 0; k < 10 && link_state !== LINK_STOPPED; k++) step(1);
    check(40'(link_state), 40'(LINK_STOPPED));
    step(RECOVER_CYC - 20);
    check(40'(link_state), 40'(LINK_STOPPED));
    for (k = 0; k < 60 && link_state !== LINK_SEEK; k++) step(1);
    check(40'(link_state), 40'(LINK_SEEK));
    $display("test link done");
  endtask
  task automatic t_cru();
    lock_cmd = 2'h1;
    step(8);
    check(40'({rst.dom_reset[DOM_RX_CORE], rst.dom_reset[DOM_TX_CORE]}), 40'h2);
    lock_cmd = 2'h3;
    step(60);
    check(40'(rst.dom_reset[DOM_RX_CORE]), 40'h0);
    $display("test recovered clock done");
  endtask
  task automatic t_ext_reset();
    int k;
    reset_cmd = 1'b1;
    step(1);
    reset_cmd = 1'b0;
    for (k = 0; k < 8 && rst.mgmt_reset !== 1'b1; k++) step(1);
    check(40'(rst), 40'h17F);
    for (k = 0; k < 20 && rst.mgmt_reset !== 1'b0; k++) step(1);
    check(40'({rst.mgmt_reset, rst.core_reset_n}), 40'h0);
    for (k = 0; k < 300 && rst.core_reset_n !== 1'b1; k++) step(1);
    check(40'(rst), 40'h080);
    $display("test external reset done");
  endtask
  task automatic t_busy();
    int bad = 0;
    int k;
    busy_cmd = 1'b1;
    step(6);
    for (k = 0; k < 50; k++) begin
      step(1);
      bad += int'(rst.mgmt_reset !== 1'b1 || rst.core_reset_n !== 1'b0);
    end
    check(40'(bad), 40'h0);
    busy_cmd = 1'b0;
    for (k = 0; k < 300 && rst.core_reset_n !== 1'b1; k++) step(1);
    check(40'(rst), 40'h080);
    $display("test reconfiguration busy done");
  endtask
  task automatic t_freeze();
    logic [3:0] l0;
    logic t0;
    l0 = link_state;
    t0 = tx_core_tick;
    ce = 1'b0;
    for (int k = 0; k < 20; k++) begin
      step(1);
      check(40'({link_state, tx_core_tick}), 40'({l0, t0}));
    end
    ce = 1'b1;
    $display("test clock enable done");
  endtask
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #50000;
    fail_count++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    reset_cmd = 1'b0;
    busy_cmd = 1'b0;
    lock_cmd = 2'h3;
    peer_active = 1'b0;
    step(2);
    t_startup();
    t_rates();
    t_divider();
    t_link();
    t_cru();
    t_ext_reset();
    t_busy();
    t_freeze();
    conclude();
  end
endmodule
`default_nettype wire

// ---- scr_far_model.sv ----
// Far-side model: system reset source, reconfiguration controller and lock indications.
`default_nettype none
module scr_far_model
  import scr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_cmd,
  input wire logic busy_cmd,
  input wire logic [1:0] lock_cmd,
  input wire scr_xcvr_rst_s xcvr_rst,
  output logic ext_reset_req,
  output logic reconfig_busy,
  output logic pll_locked,
  output logic clock_recovery_unit_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  int held;
  int pll_cnt;
  int cru_cnt;
  initial begin
    ext_reset_req = 1'b0;
    reconfig_busy = 1'b0;
    pll_locked = 1'b0;
    clock_recovery_unit_locked = 1'b0;
    held = 0;
    pll_cnt = 0;
    cru_cnt = 0;
  end
  // one source, raised off any clock edge
  always @(posedge reset_cmd) #3 ext_reset_req = 1'b1;
  // release on a rising edge after a full period
  always @(posedge core_clk) begin
    held <= ext_reset_req ? held + 1 : 0;
    if (ext_reset_req && !reset_cmd && held >= 1) begin
      ext_reset_req <= 1'b0;
    end
  end
  // busy reported in step with the clock
  always @(posedge core_clk) begin
    reconfig_busy <= busy_cmd;
  end
  // Locks take 17 cycles after their reset drops, so a stuck reset shows as a hang.
  always @(posedge core_clk) begin
    pll_cnt <= (xcvr_rst.pll_reset || !lock_cmd[0]) ? 0 : (pll_cnt < 16 ? pll_cnt + 1 : 16);
    cru_cnt <= (xcvr_rst.rx_xcvr_reset || !lock_cmd[1]) ? 0 : (cru_cnt < 16 ? cru_cnt + 1 : 16);
    pll_locked <= pll_cnt >= 16;
    clock_recovery_unit_locked <= cru_cnt >= 16;
  end
endmodule
`default_nettype wire

// ---- scr_pkg.sv ----
// Shared constants, state encodings and carrier structs for the clock and reset block.
`default_nettype none
package scr_pkg;
  // ------------------------------------------------------------
  // Domains
  // ------------------------------------------------------------
  localparam int NUM_DOM = 7;
  localparam int DOM_TX_XCVR = 0;
  localparam int DOM_RX_XCVR = 1;
  localparam int DOM_TX_CORE = 2;
  localparam int DOM_RX_CORE = 3;
  localparam int DOM_TX_STRM = 4;
  localparam int DOM_RX_STRM = 5;
  localparam int DOM_REG = 6;
  localparam int NUM_PINS = 5;
  localparam int PIN_RST_REQ = 0;
  localparam int PIN_BUSY = 1;
  localparam int PIN_PLL_LOCK = 2;
  localparam int PIN_CRU_LOCK = 3;
  localparam int PIN_PEER = 4;
  // ------------------------------------------------------------
  // Rates and divider
  // ------------------------------------------------------------
  localparam logic [1:0] BAUD_1G25 = 2'h0;
  localparam logic [1:0] BAUD_2G5 = 2'h1;
  localparam logic [1:0] BAUD_3G125 = 2'h2;
  localparam logic [1:0] BAUD_5G0 = 2'h3;
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [19:0] KHZ_62M5 = 20'h0F424;
  localparam logic [19:0] KHZ_125M = 20'h1E848;
  localparam logic [19:0] KHZ_156M25 = 20'h2625A;
  localparam logic [19:0] KHZ_250M = 20'h3D090;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TX_HOLD_NS = 1000;
  localparam int SILENT_NS = 1000;
  localparam int RECOVER_NS = 5000;
  localparam int TX_HOLD_CYC = (TX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SILENT_CYC = (SILENT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // States and carriers
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    SEQ_HOLD = 5'h01, SEQ_PLL = 5'h02, SEQ_TXREL = 5'h04, SEQ_CRU = 5'h08, SEQ_DONE = 5'h10
  } scr_seq_e;
  typedef enum logic [3:0] {
    LINK_SILENT = 4'h1, LINK_SEEK = 4'h2, LINK_INIT = 4'h4, LINK_STOPPED = 4'h8
  } scr_link_e;
  typedef struct packed {
    logic pll_reset;
    logic tx_xcvr_reset;
    logic rx_xcvr_reset;
  } scr_xcvr_rst_s;
  typedef struct packed {
    logic mgmt_reset;
    logic core_reset_n;
    logic [NUM_DOM-1:0] dom_reset;
  } scr_rst_s;
  typedef struct packed {
    logic [19:0] xcvr_khz;
    logic [19:0] core_khz;
  } scr_rate_s;

  function automatic logic [19:0] scr_xcvr_khz(input logic [1:0] baud);
    unique case (baud)
      BAUD_1G25: scr_xcvr_khz = KHZ_62M5;
      BAUD_2G5: scr_xcvr_khz = KHZ_125M;
      BAUD_3G125: scr_xcvr_khz = KHZ_156M25;
      default: scr_xcvr_khz = KHZ_250M;
    endcase
  endfunction

  function automatic logic [19:0] scr_core_khz(input logic [1:0] baud, input logic four_lane);
    scr_core_khz = four_lane ? scr_xcvr_khz(baud) : (scr_xcvr_khz(baud) >> 1);
  endfunction
endpackage
`default_nettype wire

// ---- scr_rst_sync.sv ----
// Per-domain reset synchronizer: immediate assertion, two-stage release on the domain step.
`default_nettype none
module scr_rst_sync
  import scr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic step,
  input wire logic assert_req,
  output logic rst_out
);
  typedef struct packed {
    logic [1:0] pipe;
  } scr_sync_s;
  scr_sync_s q;
  scr_sync_s next_q;

  // ------------------------------------------------------------
  // Release pipe
  // ------------------------------------------------------------
  always_comb begin
    next_q = q;
    if (ce) begin
      if (assert_req) begin
        next_q.pipe = 2'h0;
      end else if (step) begin
        next_q.pipe = {q.pipe[0], 1'b1};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rst_out = ~q.pipe[1];

  a_sync_assert: assert property (@(posedge core_clk) disable iff (srst)
    (ce && assert_req) |=> rst_out)
    else $error("domain reset not asserted after request");
  a_sync_release: assert property (@(posedge core_clk) disable iff (srst)
    $fell(rst_out) |-> $past(step) && !$past(assert_req))
    else $error("domain reset released without a step");
endmodule
`default_nettype wire
